// File: include/vnc_pkg.sv
// Purpose: Shared constants and types of the vector numeric converter.
// Assumes: Register offsets are byte addresses on a 32-bit APB.
// Notes:   Input lanes are signed fixed-point, IN_W bits, IN_FRAC fraction.
package vnc_pkg;

  // ==========================================================
  // Geometry
  localparam int LANES   = 4;
  localparam int IN_W    = 16;
  localparam int IN_FRAC = 8;
  localparam int OUT_W   = 64;
  localparam int FIFO_D  = 8;
  localparam int LAT_MAX = 8;

  // ==========================================================
  // Register map and fields
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FIX  = 8'h04;
  localparam logic [7:0] A_FLT  = 8'h08;
  localparam logic [7:0] A_LAT  = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam int NB_W       = 6;
  localparam int EW_W       = 4;
  localparam int FW_W       = 6;
  localparam int LAT_W      = 4;
  localparam int FIX_NB_LSB = 0;
  localparam int FIX_BP_LSB = 8;
  localparam int FLT_EW_LSB = 0;
  localparam int FLT_FW_LSB = 16;
  localparam int ST_CNT_LSB = 0;
  localparam int ST_OV_BIT  = 4;
  localparam int ST_EN_BIT  = 5;

  // ==========================================================
  // Modes
  typedef enum logic [1:0] {OT_BOOL = 2'h0, OT_FIX = 2'h1,
                            OT_FLT = 2'h2} vnc_otype_t;
  typedef enum logic [1:0] {QM_TRUNC = 2'h0, QM_SYM = 2'h1,
                            QM_CONV = 2'h2} vnc_qmode_t;
  typedef enum logic [1:0] {OV_SAT = 2'h0, OV_WRAP = 2'h1,
                            OV_FLAG = 2'h2} vnc_ovf_t;
  typedef enum logic [1:0] {FP_SINGLE = 2'h0, FP_DOUBLE = 2'h1,
                            FP_CUSTOM = 2'h2} vnc_prec_t;
  localparam int SGL_EXP  = 8;
  localparam int SGL_FRAC = 23;
  localparam int DBL_EXP  = 11;
  localparam int DBL_FRAC = 52;
  localparam int EXP_MIN  = 2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       pipe_max;
    vnc_prec_t  prec;
    vnc_ovf_t   ovf;
    vnc_qmode_t qmode;
    logic       sgn;
    vnc_otype_t otype;
  } vnc_ctrl_t;
  typedef struct packed {
    vnc_ctrl_t         ctrl;
    logic [NB_W-1:0]   nbits;
    logic [NB_W-1:0]   bpt;
    logic [EW_W-1:0]   ew;
    logic [FW_W-1:0]   fw;
    logic [LAT_W-1:0]  lat;
  } vnc_cfg_t;
  typedef logic [LANES-1:0][IN_W-1:0]  vnc_in_vec_t;
  typedef logic [LANES-1:0][OUT_W-1:0] vnc_out_vec_t;
  typedef struct packed {
    logic         vld;
    vnc_out_vec_t d;
  } vnc_ostage_t;
  typedef struct packed {
    logic        vld;
    vnc_in_vec_t d;
  } vnc_istage_t;

  // ==========================================================
  // Reset values
  localparam vnc_cfg_t CFG_RST = '{
    ctrl: '{pipe_max: 1'b0, prec: FP_SINGLE, ovf: OV_SAT,
            qmode: QM_TRUNC, sgn: 1'b1, otype: OT_FIX},
    nbits: 6'h10, bpt: 6'h08, ew: 4'h8, fw: 6'h17, lat: 4'h1};

endpackage

// File: rtl/vnc_converter.sv
// Purpose: Vector numeric type converter with APB setup and input FIFO.
// Assumes: Single clock pclk; srst and en are synchronous lane controls.
// Notes:   Latency counts enabled advances, not raw clock cycles.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns

// ============================================================
// Input FIFO
module vnc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   srst,
  input  wire logic                   wr_valid,
  output      logic                   wr_ready,
  input  wire logic [W-1:0]           wr_data,
  output      logic                   rd_valid,
  input  wire logic                   rd_ready,
  output      logic [W-1:0]           rd_data,
  output      logic [$clog2(D):0]     count
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } vnc_fst_t;
  vnc_fst_t s_r;
  vnc_fst_t s_nxt;
  logic     push;
  logic     pop;

  assign wr_ready = s_r.cnt != (AW+1)'(D);
  assign rd_valid = s_r.cnt != '0;
  assign rd_data  = s_r.mem[s_r.rp];
  assign count    = s_r.cnt;
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  always_comb begin
    s_nxt = s_r;
    if (srst) begin
      s_nxt.wp  = '0;
      s_nxt.rp  = '0;
      s_nxt.cnt = '0;
    end else begin
      if (push) begin
        s_nxt.mem[s_r.wp] = wr_data;
        s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop) begin
        s_nxt.rp = s_r.rp + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ============================================================
// Converter top
module vnc_converter (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output      logic [31:0]            prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  input  wire logic                   srst,
  input  wire logic                   en,
  input  wire logic                   in_valid,
  output      logic                   in_ready,
  input  wire vnc_pkg::vnc_in_vec_t   in_data,
  output      logic                   out_valid,
  input  wire logic                   out_ready,
  output      vnc_pkg::vnc_out_vec_t  out_data
);
  localparam int CW = $bits(vnc_pkg::vnc_ctrl_t);
  localparam int FCW = $clog2(vnc_pkg::FIFO_D) + 1;

  typedef struct packed {
    vnc_pkg::vnc_cfg_t                          cfg;
    logic [31:0]                                rdata;
    logic                                       err;
    vnc_pkg::vnc_istage_t                       ireg;
    vnc_pkg::vnc_ostage_t [vnc_pkg::LAT_MAX-1:0] dl;
  } vnc_st_t;

  vnc_st_t               s_r;
  vnc_st_t               s_nxt;
  logic                  f_valid;
  logic                  f_ready;
  vnc_pkg::vnc_in_vec_t  f_data;
  logic [FCW-1:0]        f_cnt;
  vnc_pkg::vnc_in_vec_t  src;
  logic                  src_v;
  vnc_pkg::vnc_out_vec_t cv;
  logic                  pipe;
  logic                  advance;
  int                    lc;
  int                    tap;

  // ==========================================================
  // Arithmetic helpers
  function automatic logic [63:0] vnc_rnd(logic signed [63:0] x, int sh,
                                          vnc_pkg::vnc_qmode_t q);
    logic signed [63:0] t;
    logic [63:0]        rem;
    logic [63:0]        half;
    logic               up;
    up = 1'b0;
    if (sh <= 0) begin
      return x;
    end
    t    = x >>> sh;
    rem  = x & ((64'h1 << sh) - 64'h1);
    half = 64'h1 << (sh - 1);
    case (q)
      vnc_pkg::QM_SYM: begin
        up = rem > half || (rem == half && !x[63]);
      end
      vnc_pkg::QM_CONV: begin
        up = rem > half || (rem == half && t[0]);
      end
      default: begin
        up = 1'b0;
      end
    endcase
    return t + 64'(up);
  endfunction

  function automatic logic [63:0] vnc_cvt(logic [vnc_pkg::IN_W-1:0] x,
                                          vnc_pkg::vnc_cfg_t c);
    logic signed [63:0] xs;
    logic signed [63:0] r;
    logic signed [63:0] mx;
    logic signed [63:0] mn;
    logic [63:0]        mag;
    logic [63:0]        m;
    logic [63:0]        res;
    logic               sat;
    int                 n;
    int                 lead;
    int                 ew;
    int                 fw;
    int                 e;
    int                 emax;
    xs   = 64'(signed'(x));
    res  = '0;
    r    = '0;
    mx   = '0;
    mn   = '0;
    m    = '0;
    lead = 0;
    e    = 0;
    sat  = c.ctrl.ovf == vnc_pkg::OV_SAT;
    n    = (c.nbits == '0) ? 1 : int'(c.nbits);
    mag  = xs[63] ? 64'(-xs) : 64'(xs);
    case (c.ctrl.prec)
      vnc_pkg::FP_DOUBLE: begin
        ew = vnc_pkg::DBL_EXP;
        fw = vnc_pkg::DBL_FRAC;
      end
      vnc_pkg::FP_CUSTOM: begin
        ew = (int'(c.ew) < vnc_pkg::EXP_MIN) ? vnc_pkg::EXP_MIN
                                             : int'(c.ew);
        fw = int'(c.fw);
      end
      default: begin
        ew = vnc_pkg::SGL_EXP;
        fw = vnc_pkg::SGL_FRAC;
      end
    endcase
    emax = (1 << ew) - 2;
    case (c.ctrl.otype)
      vnc_pkg::OT_BOOL: begin
        res = {63'h0, |x};
      end
      vnc_pkg::OT_FLT: begin
        if (mag != '0) begin
          for (int i = 0; i < vnc_pkg::IN_W; i++) begin
            if (mag[i]) begin
              lead = i;
            end
          end
          if (lead > fw) begin
            m = vnc_rnd(signed'(mag), lead - fw, c.ctrl.qmode);
            if (m[fw+1]) begin
              m = m >> 1;
              lead = lead + 1;
            end
          end else begin
            m = mag << (fw - lead);
          end
          e = lead - vnc_pkg::IN_FRAC + (1 << (ew - 1)) - 1;
          if (e > emax) begin
            m = sat ? '1 : '0;
            e = sat ? emax : emax + 1;
          end
          if (e >= 1) begin
            res = (64'(e) << fw) | (m & ((64'h1 << fw) - 64'h1));
          end
        end
        res = res | (64'(xs[63]) << (ew + fw));
      end
      default: begin
        if (int'(c.bpt) >= vnc_pkg::IN_FRAC) begin
          r = xs <<< (int'(c.bpt) - vnc_pkg::IN_FRAC);
        end else begin
          r = vnc_rnd(xs, vnc_pkg::IN_FRAC - int'(c.bpt), c.ctrl.qmode);
        end
        if (c.ctrl.sgn) begin
          mx = (64'sd1 <<< (n - 1)) - 64'sd1;
          mn = -mx - 64'sd1;
        end else begin
          mx = (64'sd1 <<< n) - 64'sd1;
          mn = '0;
        end
        if (sat && r > mx) begin
          r = mx;
        end else if (sat && r < mn) begin
          r = mn;
        end
        res = 64'(r) & ((64'h1 << n) - 64'h1);
      end
    endcase
    return res;
  endfunction

  function automatic logic [2:0] vnc_dec(logic [7:0] a);
    if (a == vnc_pkg::A_CTRL) begin
      return 3'h0;
    end else if (a == vnc_pkg::A_FIX) begin
      return 3'h1;
    end else if (a == vnc_pkg::A_FLT) begin
      return 3'h2;
    end else if (a == vnc_pkg::A_LAT) begin
      return 3'h3;
    end else if (a == vnc_pkg::A_STAT) begin
      return 3'h4;
    end else begin
      return 3'h7;
    end
  endfunction

  // ==========================================================
  // Input buffer
  vnc_fifo #(
    .W ($bits(vnc_pkg::vnc_in_vec_t)),
    .D (vnc_pkg::FIFO_D)
  ) u_fifo (
    .clk      (pclk),
    .rst_n    (presetn),
    .srst     (srst),
    .wr_valid (in_valid),
    .wr_ready (f_ready),
    .wr_data  (in_data),
    .rd_valid (f_valid),
    .rd_ready (advance),
    .rd_data  (f_data),
    .count    (f_cnt)
  );
  assign in_ready = f_ready;

  // ==========================================================
  // Lane converters
  assign pipe  = s_r.cfg.ctrl.pipe_max && s_r.cfg.lat != '0;
  assign src   = pipe ? s_r.ireg.d : f_data;
  assign src_v = pipe ? s_r.ireg.vld : f_valid;

  genvar gi;
  generate
    for (gi = 0; gi < vnc_pkg::LANES; gi++) begin : g_lane
      assign cv[gi] = vnc_cvt(src[gi], s_r.cfg);
    end
  endgenerate

  // ==========================================================
  // Output tap
  // A latency change while samples are in flight may repeat or
  // drop those samples; set latency while the lanes are idle.
  always_comb begin
    lc  = (int'(s_r.cfg.lat) > vnc_pkg::LAT_MAX) ? vnc_pkg::LAT_MAX
                                                 : int'(s_r.cfg.lat);
    tap = pipe ? lc - 1 : lc;
    if (tap == 0) begin
      out_valid = src_v;
      out_data  = cv;
    end else begin
      out_valid = s_r.dl[tap-1].vld;
      out_data  = s_r.dl[tap-1].d;
    end
  end

  // Stalls when en is low or when a valid result is refused downstream
  assign advance = en && (out_ready || !out_valid);
  assign pready  = 1'b1;
  assign prdata  = s_r.rdata;
  assign pslverr = s_r.err;

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    if (psel && !penable) begin
      s_nxt.err   = vnc_dec(paddr) == 3'h7;
      s_nxt.rdata = '0;
      if (!pwrite) begin
        case (vnc_dec(paddr))
          3'h0: s_nxt.rdata[CW-1:0] = s_r.cfg.ctrl;
          3'h1: begin
            s_nxt.rdata[vnc_pkg::FIX_NB_LSB +: vnc_pkg::NB_W] =
              s_r.cfg.nbits;
            s_nxt.rdata[vnc_pkg::FIX_BP_LSB +: vnc_pkg::NB_W] =
              s_r.cfg.bpt;
          end
          3'h2: begin
            s_nxt.rdata[vnc_pkg::FLT_EW_LSB +: vnc_pkg::EW_W] = s_r.cfg.ew;
            s_nxt.rdata[vnc_pkg::FLT_FW_LSB +: vnc_pkg::FW_W] = s_r.cfg.fw;
          end
          3'h3: s_nxt.rdata[vnc_pkg::LAT_W-1:0] = s_r.cfg.lat;
          3'h4: begin
            s_nxt.rdata[vnc_pkg::ST_CNT_LSB +: FCW] = f_cnt;
            s_nxt.rdata[vnc_pkg::ST_OV_BIT] = out_valid;
            s_nxt.rdata[vnc_pkg::ST_EN_BIT] = en;
          end
          default: s_nxt.rdata = '0;
        endcase
      end
    end
    if (psel && penable && pwrite) begin
      case (vnc_dec(paddr))
        3'h0: s_nxt.cfg.ctrl = vnc_pkg::vnc_ctrl_t'(pwdata[CW-1:0]);
        3'h1: begin
          s_nxt.cfg.nbits = pwdata[vnc_pkg::FIX_NB_LSB +: vnc_pkg::NB_W];
          s_nxt.cfg.bpt   = pwdata[vnc_pkg::FIX_BP_LSB +: vnc_pkg::NB_W];
        end
        3'h2: begin
          s_nxt.cfg.ew = pwdata[vnc_pkg::FLT_EW_LSB +: vnc_pkg::EW_W];
          s_nxt.cfg.fw = pwdata[vnc_pkg::FLT_FW_LSB +: vnc_pkg::FW_W];
        end
        3'h3: s_nxt.cfg.lat = pwdata[vnc_pkg::LAT_W-1:0];
        default: s_nxt.cfg = s_r.cfg;
      endcase
    end
    if (srst) begin
      s_nxt.ireg = '0;
      s_nxt.dl   = '0;
    end else if (advance) begin
      s_nxt.ireg.vld = f_valid;
      s_nxt.ireg.d   = f_data;
      s_nxt.dl[0].vld = src_v;
      s_nxt.dl[0].d   = cv;
      for (int i = 1; i < vnc_pkg::LAT_MAX; i++) begin
        s_nxt.dl[i] = s_r.dl[i-1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.cfg <= vnc_pkg::CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// File: verification/vnc_checker.sv
// Purpose: Port-level timing checks of the vector converter.
// Assumes: Only top-level ports are visible.
// Notes:   Lane values are judged by the bench scoreboard.
`timescale 1ns/1ns
module vnc_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  srst,
  input wire logic                  en,
  input wire logic                  in_valid,
  input wire logic                  in_ready,
  input wire logic                  out_valid,
  input wire logic                  out_ready,
  input wire vnc_pkg::vnc_out_vec_t out_data
);
  logic bad;
  assign bad = paddr > vnc_pkg::A_STAT || paddr[1:0] != 2'h0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ============================================================
  // Sequences
  sequence s_bad_acc;
    psel && !penable && bad ##1 psel && penable;
  endsequence
  sequence s_good_acc;
    psel && !penable && !bad ##1 psel && penable;
  endsequence
  // ============================================================
  // Properties
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_bad_err: assert property (s_bad_acc |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_good_ok: assert property (s_good_acc |-> !pslverr)
    else $error("mapped access refused");
  a_err_stand: assert property (pslverr && !psel |=> pslverr)
    else $error("pslverr dropped without new setup");
  a_en_hold: assert property (out_valid && !en && !srst
    |=> out_valid && $stable(out_data)) else $error("output moved, en low");
  a_stall_hold: assert property (out_valid && en && !out_ready && !srst
    |=> out_valid && $stable(out_data)) else $error("output moved on stall");
  a_srst_clear: assert property (srst && !in_valid
    |=> in_ready && !out_valid) else $error("lane reset did not clear");
  a_full_stay: assert property (!in_ready && !en && !srst
    |=> !in_ready) else $error("FIFO drained while en low");
endmodule

bind vnc_converter vnc_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .srst(srst), .en(en), .in_valid(in_valid), .in_ready(in_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
);

// File: verification/vnc_sink.sv
// Purpose: Downstream consumer model of the converter output.
// Assumes: Ready may be dropped at any cycle.
// Notes:   Slow mode stalls on a pseudo-random pattern.
`timescale 1ns/1ns
module vnc_sink (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  output      logic out_ready
);
  logic [4:0] lfsr_r;
  // A busy consumer stalls irregularly, so holds are seen at odd spots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= 5'h15;
      out_ready <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[3:0], lfsr_r[4] ^ lfsr_r[2]};
      out_ready <= slow ? lfsr_r[0] : 1'b1;
    end
  end
endmodule

// File: verification/vnc_converter_bench.sv
// Purpose: Self-checking bench of the vector converter.
// Assumes: Input lanes are signed 16 bits with 8 fraction bits.
// Notes:   Expected lanes are queued when a word is pushed.
`timescale 1ns/1ns
module vnc_converter_bench;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  srst;
  logic                  en = 1'b0;
  logic                  in_valid;
  logic                  in_ready;
  logic                  out_valid;
  logic                  out_ready;
  logic                  slow;
  logic [1:0]            en_mode;
  logic [31:0]           seed;
  logic [31:0]           eseed = 32'h1206;
  logic [31:0]           rd;
  logic                  er;
  int                    n_errors;
  int                    samples_checked;
  int                    cyc;
  int                    ot, qm, ov, sg, nb, bp, pr, n;
  int                    lt[5] = '{0, 1, 3, 3, 9};
  vnc_pkg::vnc_in_vec_t  in_data;
  vnc_pkg::vnc_out_vec_t out_data;
  vnc_pkg::vnc_out_vec_t q[$];
  localparam vnc_pkg::vnc_in_vec_t TIE = {16'h0019, 16'hFFE8, 16'h0028,
                                          16'h0018};
  localparam vnc_pkg::vnc_in_vec_t FV = {16'h0100, 16'hFE00, 16'h0000,
                                         16'h0100};

  vnc_converter uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .srst(srst),
    .en(en), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  vnc_sink sink (.pclk(pclk), .presetn(presetn), .slow(slow),
    .out_ready(out_ready));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ============================================================
  // Reference model
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [63:0] fx(logic [15:0] x);
    longint v, r, h, mx, mn;
    int     s;
    s = 8 - bp;
    v = longint'($signed(x)) >>> s;
    r = longint'($signed(x)) & ((longint'(1) << s) - 1);
    h = longint'(1) << (s - 1);
    if (qm != 0 && s > 0 && (r > h || r == h && (qm == 1 ? !x[15] : v[0])))
      v = v + 1;
    mx = sg ? (longint'(1) << (nb - 1)) - 1 : (longint'(1) << nb) - 1;
    mn = sg ? -(longint'(1) << (nb - 1)) : 0;
    if (ov == 0 && v > mx) v = mx;
    if (ov == 0 && v < mn) v = mn;
    return v & ((longint'(1) << nb) - 1);
  endfunction
  function automatic logic [63:0] ex(logic [15:0] x);
    if (ot == 0) return {63'h0, x != 16'h0};
    if (ot == 1) return fx(x);
    if (x == 16'h0) return 64'h0;
    if (pr == 0) return x[15] ? 64'hC0000000 : 64'h3F800000;
    if (pr == 1) return x[15] ? 64'hC000000000000000 : 64'h3FF0000000000000;
    return x[15] ? 64'hC000 : 64'h3C00;
  endfunction

  // ============================================================
  // Tasks
  task chk(input logic [255:0] s, input logic [255:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cfg(input int l, input int pm);
    apb(1, vnc_pkg::A_CTRL, {22'h0, pm[0], pr[1:0], ov[1:0], qm[1:0],
        sg[0], ot[1:0]});
    apb(1, vnc_pkg::A_FIX, {18'h0, bp[5:0], 2'h0, nb[5:0]});
    apb(1, vnc_pkg::A_FLT, 32'h000A0005);
    apb(1, vnc_pkg::A_LAT, l);
  endtask
  task push(input vnc_pkg::vnc_in_vec_t v);
    vnc_pkg::vnc_out_vec_t e;
    for (int i = 0; i < vnc_pkg::LANES; i++) e[i] = ex(v[i]);
    @(posedge pclk);
    in_valid <= 1'b1;
    in_data <= v;
    q.push_back(e);
    do @(posedge pclk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
  endtask
  task pushr();
    vnc_pkg::vnc_in_vec_t v;
    for (int i = 0; i < vnc_pkg::LANES; i++) begin
      seed = xs(seed);
      v[i] = seed[15:0];
    end
    push(v);
  endtask
  task drain();
    while (q.size() > 0) @(posedge pclk);
    repeat (10) @(posedge pclk);
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  task summarize();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ============================================================
  // Enable driver, scoreboard and timeout
  always @(posedge pclk) begin
    eseed <= xs(eseed);
    en <= en_mode == 2'h0 ? 1'b1 : en_mode == 2'h1 ? 1'b0 : eseed[3];
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      summarize();
    end else if (presetn && out_valid === 1'b1 && out_ready && en &&
                 !srst) begin
      if (q.size() == 0) chk(1, 0);
      else chk(out_data, q.pop_front());
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, srst} = '0;
    {in_valid, in_data, slow, en_mode} = '0;
    {n_errors, samples_checked, cyc} = '0;
    seed = 32'h1206;
    {ot, qm, ov, sg, nb, bp, pr} = {32'd1, 32'd0, 32'd0, 32'd1, 32'd16,
                                     32'd8, 32'd0};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, vnc_pkg::A_CTRL, 0);
    chk(rd, 32'h005);
    apb(0, vnc_pkg::A_FIX, 0);
    chk(rd, 32'h0810);
    apb(0, vnc_pkg::A_FLT, 0);
    chk(rd, 32'h00170008);
    apb(0, vnc_pkg::A_LAT, 0);
    chk(rd, 1);
    apb(0, 8'h14, 0);
    chk(er, 1);
    tend("regs");
    repeat (4) pushr();
    drain();
    tend("default");
    nb = 8;
    bp = 4;
    for (qm = 0; qm < 3; qm++)
      for (ov = 0; ov < 3; ov++)
        for (sg = 0; sg < 2; sg++) begin
          cfg(1, 0);
          push(TIE);
          repeat (2) pushr();
          drain();
        end
    tend("fixed");
    {qm, ov, sg, nb, bp} = {32'd0, 32'd0, 32'd1, 32'd16, 32'd8};
    for (pr = 0; pr < 3; pr++) begin
      ot = 2;
      cfg(1, 0);
      push(FV);
      drain();
    end
    ot = 0;
    cfg(1, 0);
    push(FV);
    drain();
    ot = 1;
    tend("float");
    for (int i = 0; i < 5; i++) begin
      cfg(lt[i], i % 2);
      pushr();
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (out_valid !== 1'b1 && n < 30);
      chk(n, (lt[i] > vnc_pkg::LAT_MAX ? vnc_pkg::LAT_MAX : lt[i]) + 1);
      drain();
    end
    tend("latency");
    cfg(1, 0);
    en_mode = 2'h1;
    repeat (2) @(posedge pclk);
    repeat (8) pushr();
    @(posedge pclk);
    chk(in_ready, 0);
    apb(0, vnc_pkg::A_STAT, 0);
    chk(rd & 32'h3F, 32'h08);
    srst <= 1'b1;
    @(posedge pclk);
    srst <= 1'b0;
    q.delete();
    @(posedge pclk);
    chk(in_ready, 1);
    chk(out_valid, 0);
    tend("hold");
    cfg(3, 1);
    en_mode = 2'h2;
    slow = 1'b1;
    repeat (12) pushr();
    drain();
    tend("stream");
    summarize();
  end
endmodule
